// ==== hdl/audio_sync_map.vh ====
// register offsets, field positions, reset values and timing counts
`ifndef AUDIO_SYNC_MAP_VH
`define AUDIO_SYNC_MAP_VH

`define A_CTRL 8'h00
`define A_BASE 8'h04
`define A_PLAY 8'h08
`define A_COARSE 8'h0C
`define A_FINE 8'h10
`define A_STATUS 8'h14
`define A_REF_RATE 8'h18
`define A_SPDIF_RATE 8'h1C
`define A_INT_RATE 8'h20

`define F_AUTO 0
`define F_PREF_LO 1
`define F_PREF_HI 2
`define F_SPIN_LO 3
`define F_SPIN_HI 4
`define F_OPT_OUT 5
`define F_BASE_WCK 6
`define F_EXP_SEL 7
`define F_SYN_EN 8
`define F_COARSE_ACT 9
`define F_FINE_ACT 10
`define F_PRESET_LO 11
`define F_PRESET_HI 13
`define F_MULT_LO 14
`define F_MULT_HI 15
`define CTRL_W 16

`define RST_CTRL 16'h0000
`define RST_RATE 18'h0_BB80
`define RATE_MIN 18'h0_6D60
`define RATE_MAX 18'h3_0D40
`define RATE_48K 18'h0_BB80
`define RATE_96K 18'h1_7700
`define RATE_TOL 18'h0_01F4

`define ST_NOLOCK 2'h0
`define ST_LOCK 2'h1
`define ST_SYNC 2'h2
`define REF_WCK 2'h0
`define REF_OPT 2'h1
`define REF_SPDIF 2'h2
`define REF_NONE 2'h3

`define PRE_NONE 3'h0
`define PRE_UP_SMALL 3'h1
`define PRE_DN_SMALL 3'h2
`define PRE_UP_BIG 3'h3
`define PRE_DN_BIG 3'h4
`define DIV_SMALL 20'h0_03E8
`define DIV_BIG 20'h0_0019

`define CLK_MHZ 125
`define GATE_MS 1000
`define GATE_CYC 27'h773_5940
`define NCO_HALF 27'h3B9_ACA0

`endif

// ==== hdl/audio_sync_source_select.v ====
// sample clock source selection, rate synthesis and sync monitoring
`timescale 1ns/1ps
`default_nettype none
`include "audio_sync_map.vh"

// Function
// - two clock modes: internal clock, or automatic following the preferred input.
// - automatic mode falls back to next valid input when preferred one fails.
// - only word clock, optical multichannel and S/PDIF inputs are candidates.
// - each candidate reports no lock, lock, or sync state.
// - active reference and its measured rate are reported.
// - system status shows master or slave.
// - word clock out equals sample rate, or base rate 32-48k if option set.
// - four-way S/PDIF receiver source select.
// - S/PDIF always on coax out, also optical out when selected.
// - S/PDIF input rate measured regardless of reference.
// - expansion option takes multichannel data from internal connector.
// - synthesized rate only applies in internal-clock mode, this card only.
// - synthesizer enable gates all synth settings, else standard rate.
// - synth rate = base times multiplier plus active fader offsets.
// - coarse and fine offsets in 1 Hz steps, each gated by its flag.
// - preset pull up/down rates of 0.1% and 4%.
// - settings act at once without commit; avoid changes while streaming.
// - no valid input in automatic mode gives internal clock and master.
// - follow an input only when its rate matches playback rate.
module audio_sync_source_select #(
    parameter [26:0] GATE_CYCLES = `GATE_CYC
) (
    input wire CLK_I,
    input wire RESET_I,
    input wire PSEL_I,
    input wire PENABLE_I,
    input wire PWRITE_I,
    input wire [7:0] PADDR_I,
    input wire [31:0] PWDATA_I,
    output wire [31:0] PRDATA_O,
    output wire PREADY_O,
    output wire PSLVERR_O,
    input wire WCK_IN_I,
    input wire OPT_IN_I,
    input wire EXP_IN_I,
    input wire SPDIF_OPT_I,
    input wire SPDIF_COAX_I,
    input wire SPDIF_INT_I,
    input wire SPDIF_AES_I,
    input wire SPDIF_TX_I,
    input wire OPT_TX_I,
    output wire SPDIF_COAX_O,
    output wire OPT_OUT_O,
    output wire SPDIF_RX_O,
    output wire WCK_OUT_O,
    output wire SLAVE_O,
    output wire [1:0] REF_SEL_O,
    output wire [17:0] SAMPLE_RATE_O
);

    function in_range;
        input [17:0] r;
        begin
            in_range = (r >= `RATE_MIN) && (r <= `RATE_MAX);
        end
    endfunction

    function close_to;
        input [17:0] a;
        input [17:0] b;
        begin
            close_to = (a > b) ? (a - b <= `RATE_TOL) : (b - a <= `RATE_TOL);
        end
    endfunction

    reg [`CTRL_W-1:0] ctrl_ff;
    reg [17:0] base_ff, play_ff;
    reg [15:0] coarse_ff, fine_ff;
    reg [31:0] prdata_ff;
    reg pready_ff, pslverr_ff;
    reg [6:0] pin_s1_ff, pin_s2_ff;
    reg [17:0] synth_ff;
    reg [1:0] ref_ff;
    reg slave_ff;
    reg [26:0] gate_ff;
    reg [26:0] nco_ff;
    reg wck_ff, coax_ff, optout_ff, sprx_ff;
    reg [17:0] rate_out_ff;

    wire auto_mode = ctrl_ff[`F_AUTO];
    wire [1:0] pref = ctrl_ff[`F_PREF_HI:`F_PREF_LO];
    wire [1:0] spin = ctrl_ff[`F_SPIN_HI:`F_SPIN_LO];
    wire [2:0] preset = ctrl_ff[`F_PRESET_HI:`F_PRESET_LO];
    wire [1:0] mult = ctrl_ff[`F_MULT_HI:`F_MULT_LO];
    wire gate_tick = (gate_ff == GATE_CYCLES - 27'h000_0001);

    // candidate inputs after synchronisers
    reg spdif_src;
    always @* begin
        case (spin)
            2'h0: spdif_src = pin_s2_ff[3];
            2'h1: spdif_src = pin_s2_ff[4];
            2'h2: spdif_src = pin_s2_ff[5];
            default: spdif_src = pin_s2_ff[6];
        endcase
    end
    wire opt_src = ctrl_ff[`F_EXP_SEL] ? pin_s2_ff[2] : pin_s2_ff[1];
    wire [2:0] src = {spdif_src, opt_src, pin_s2_ff[0]};

    always @(posedge CLK_I) begin
        if (RESET_I) begin
            pin_s1_ff <= 7'h00;
            pin_s2_ff <= 7'h00;
        end else begin
            pin_s1_ff <= {SPDIF_AES_I, SPDIF_INT_I, SPDIF_COAX_I, SPDIF_OPT_I, EXP_IN_I, OPT_IN_I, WCK_IN_I};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    always @(posedge CLK_I) begin
        if (RESET_I || gate_tick)
            gate_ff <= 27'h000_0000;
        else
            gate_ff <= gate_ff + 27'h000_0001;
    end

    // per-input edge counting over the gate window
    wire [53:0] rate_all;
    wire [2:0] valid;
    wire [2:0] ok;
    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_in
            reg prev_ff;
            reg [17:0] cnt_ff, rate_ff;
            wire edge_seen = src[i] && !prev_ff;
            always @(posedge CLK_I) begin
                if (RESET_I) begin
                    prev_ff <= 1'b0;
                    cnt_ff <= 18'h0_0000;
                    rate_ff <= 18'h0_0000;
                end else begin
                    prev_ff <= src[i];
                    if (gate_tick) begin
                        rate_ff <= cnt_ff;
                        cnt_ff <= {17'h0_0000, edge_seen};
                    end else if (edge_seen && cnt_ff != 18'h3_FFFF) begin
                        cnt_ff <= cnt_ff + 18'h0_0001;
                    end
                end
            end
            assign rate_all[i*18 +: 18] = rate_ff;
            assign valid[i] = in_range(rate_ff);
            assign ok[i] = valid[i] && close_to(rate_ff, play_ff);
        end
    endgenerate

    // rate synthesizer
    reg [19:0] scaled, preset_rate;
    reg [20:0] sum;
    always @* begin
        case (mult)
            2'h1: scaled = {1'b0, base_ff, 1'b0};
            2'h2: scaled = {base_ff, 2'h0};
            default: scaled = {2'h0, base_ff};
        endcase
        case (preset)
            `PRE_UP_SMALL: preset_rate = scaled + scaled / `DIV_SMALL;
            `PRE_DN_SMALL: preset_rate = scaled - scaled / `DIV_SMALL;
            `PRE_UP_BIG: preset_rate = scaled + scaled / `DIV_BIG;
            `PRE_DN_BIG: preset_rate = scaled - scaled / `DIV_BIG;
            default: preset_rate = scaled;
        endcase
        sum = {1'b0, preset_rate};
        if (ctrl_ff[`F_COARSE_ACT])
            sum = sum + {{5{coarse_ff[15]}}, coarse_ff};
        if (ctrl_ff[`F_FINE_ACT])
            sum = sum + {{5{fine_ff[15]}}, fine_ff};
    end

    // internal rate: synthesizer only when enabled and in internal mode
    wire [17:0] int_rate = (!auto_mode && ctrl_ff[`F_SYN_EN]) ? synth_ff : play_ff;

    // reference scan: preferred input first, then the others in turn
    reg [1:0] c0, c1, c2, nxt_ref;
    reg nxt_slave;
    always @* begin
        c0 = (pref == `REF_NONE) ? `REF_WCK : pref;
        c1 = (c0 == `REF_SPDIF) ? `REF_WCK : c0 + 2'h1;
        c2 = (c1 == `REF_SPDIF) ? `REF_WCK : c1 + 2'h1;
        nxt_ref = `REF_NONE;
        nxt_slave = 1'b0;
        if (auto_mode) begin
            if (ok[c0]) begin
                nxt_ref = c0;
                nxt_slave = 1'b1;
            end else if (ok[c1]) begin
                nxt_ref = c1;
                nxt_slave = 1'b1;
            end else if (ok[c2]) begin
                nxt_ref = c2;
                nxt_slave = 1'b1;
            end // else internal clock, master
        end
    end

    wire [17:0] ref_rate = slave_ff ? rate_all[ref_ff*18 +: 18] : 18'h0_0000;
    wire [17:0] act_rate = slave_ff ? ref_rate : int_rate;

    // per-input state
    reg [5:0] st;
    integer k;
    always @* begin
        st = 6'h00;
        for (k = 0; k < 3; k = k + 1) begin
            if (valid[k] && close_to(rate_all[k*18 +: 18], act_rate))
                st[k*2 +: 2] = `ST_SYNC;
            else if (valid[k])
                st[k*2 +: 2] = `ST_LOCK;
        end
    end

    // word clock output rate
    wire [17:0] wck_rate = !ctrl_ff[`F_BASE_WCK] ? act_rate :
        (act_rate > `RATE_96K) ? {2'h0, act_rate[17:2]} :
        (act_rate > `RATE_48K) ? {1'b0, act_rate[17:1]} : act_rate;
    wire [26:0] nco_sum = nco_ff + {9'h000, wck_rate};

    always @(posedge CLK_I) begin
        if (RESET_I) begin
            synth_ff <= `RST_RATE;
            ref_ff <= `REF_NONE;
            slave_ff <= 1'b0;
            nco_ff <= 27'h000_0000;
            wck_ff <= 1'b0;
            coax_ff <= 1'b0;
            optout_ff <= 1'b0;
            sprx_ff <= 1'b0;
            rate_out_ff <= `RST_RATE;
        end else begin
            synth_ff <= sum[17:0];
            ref_ff <= nxt_ref;
            slave_ff <= nxt_slave;
            rate_out_ff <= act_rate;
            if (nco_sum >= `NCO_HALF) begin
                nco_ff <= nco_sum - `NCO_HALF;
                wck_ff <= !wck_ff;
            end else begin
                nco_ff <= nco_sum;
            end
            coax_ff <= SPDIF_TX_I;
            optout_ff <= ctrl_ff[`F_OPT_OUT] ? SPDIF_TX_I : OPT_TX_I;
            sprx_ff <= spdif_src;
        end
    end

    // apb slave, one wait state
    wire acc = PSEL_I && PENABLE_I && pready_ff;
    reg [31:0] rd;
    reg hit;
    always @* begin
        rd = 32'h0000_0000;
        hit = 1'b1;
        case (PADDR_I)
            `A_CTRL: rd = {16'h0000, ctrl_ff};
            `A_BASE: rd = {14'h0000, base_ff};
            `A_PLAY: rd = {14'h0000, play_ff};
            `A_COARSE: rd = {16'h0000, coarse_ff};
            `A_FINE: rd = {16'h0000, fine_ff};
            `A_STATUS: rd = {23'h00_0000, slave_ff, ref_ff, st};
            `A_REF_RATE: rd = {14'h0000, ref_rate};
            `A_SPDIF_RATE: rd = {14'h0000, rate_all[53:36]};
            `A_INT_RATE: rd = {14'h0000, int_rate};
            default: hit = 1'b0;
        endcase
    end

    always @(posedge CLK_I) begin
        if (RESET_I) begin
            ctrl_ff <= `RST_CTRL;
            base_ff <= `RST_RATE;
            play_ff <= `RST_RATE;
            coarse_ff <= 16'h0000;
            fine_ff <= 16'h0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= PSEL_I && PENABLE_I && !pready_ff;
            pslverr_ff <= PSEL_I && PENABLE_I && !pready_ff && !hit;
            prdata_ff <= (PSEL_I && PENABLE_I && !pready_ff && !PWRITE_I) ? rd : 32'h0000_0000;
            if (acc && PWRITE_I) begin
                case (PADDR_I)
                    `A_CTRL: ctrl_ff <= PWDATA_I[`CTRL_W-1:0];
                    `A_BASE: base_ff <= PWDATA_I[17:0];
                    `A_PLAY: play_ff <= PWDATA_I[17:0];
                    `A_COARSE: coarse_ff <= PWDATA_I[15:0];
                    `A_FINE: fine_ff <= PWDATA_I[15:0];
                    default: ;
                endcase
            end
        end
    end

    assign PRDATA_O = prdata_ff;
    assign PREADY_O = pready_ff;
    assign PSLVERR_O = pslverr_ff;
    assign SPDIF_COAX_O = coax_ff;
    assign OPT_OUT_O = optout_ff;
    assign SPDIF_RX_O = sprx_ff;
    assign WCK_OUT_O = wck_ff;
    assign SLAVE_O = slave_ff;
    assign REF_SEL_O = ref_ff;
    assign SAMPLE_RATE_O = rate_out_ff;

endmodule // audio_sync_source_select
`default_nettype wire

// ==== testbench/audio_src_model.sv ====
// far-side audio gear: frame sync trains on expansion and s/pdif pins
`timescale 1ns/1ps
`default_nettype none
module audio_src_model (
    input wire logic run_i,
    output logic exp_o,
    output logic spdif_o
);
    // off the clock edges; stands low when stopped
    initial begin
        exp_o = 1'b0;
        spdif_o = 1'b0;
        #2;
        forever begin
            #8;
            exp_o = run_i ? ~exp_o : 1'b0;
            spdif_o = run_i ? ~spdif_o : 1'b0;
        end
    end
endmodule // audio_src_model
`default_nettype wire

// ==== testbench/audio_sync_assertions.sv ====
// port-level checks on the sync source block
`timescale 1ns/1ps
`default_nettype none
module audio_sync_checks #(
    parameter [26:0] GATE_CYCLES = 27'h000_0001
) (
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic [31:0] PRDATA_O,
    input wire logic SPDIF_TX_I,
    input wire logic OPT_TX_I,
    input wire logic SPDIF_OPT_I,
    input wire logic SPDIF_COAX_I,
    input wire logic SPDIF_INT_I,
    input wire logic SPDIF_AES_I,
    input wire logic SPDIF_COAX_O,
    input wire logic OPT_OUT_O,
    input wire logic SPDIF_RX_O,
    input wire logic SLAVE_O,
    input wire logic [1:0] REF_SEL_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RESET_I);
    ready_one_cycle_a:
        assert property (PREADY_O |=> !PREADY_O) else $error("ready held too long");
    ready_after_access_a:
        assert property (PSEL_I && $rose(PENABLE_I) |=> PREADY_O) else $error("ready late");
    ready_has_cause_a:
        assert property (PREADY_O |-> $past(PSEL_I) && $past(PENABLE_I)) else $error("ready unasked");
    err_with_ready_a:
        assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
    rdata_idle_zero_a:
        assert property (!PREADY_O |-> PRDATA_O == 32'h0000_0000) else $error("read data not idle");
    coax_follows_tx_a:
        assert property (!$past(RESET_I) |-> SPDIF_COAX_O == $past(SPDIF_TX_I)) else $error("coax out wrong");
    optical_common_a:
        assert property (!$past(RESET_I) && $past(SPDIF_TX_I) == $past(OPT_TX_I)
            |-> OPT_OUT_O == $past(OPT_TX_I)) else $error("optical out wrong");
    rx_any_source_a:
        assert property ((SPDIF_OPT_I && SPDIF_COAX_I && SPDIF_INT_I && SPDIF_AES_I) [*5]
            |-> SPDIF_RX_O) else $error("receiver input lost");
    slave_has_ref_a:
        assert property (SLAVE_O |-> REF_SEL_O != 2'h3) else $error("slave without reference");
    master_no_ref_a:
        assert property (!SLAVE_O |-> REF_SEL_O == 2'h3) else $error("master with reference");
endmodule // audio_sync_checks
`default_nettype wire

// ==== testbench/tb_audio_sync_source_select.sv ====
// self-checking bench for the sync source block
`timescale 1ns/1ps
`default_nettype none
`include "audio_sync_map.vh"
module tb_audio_sync_source_select;
localparam [26:0] GATE = 27'h000_EA60;
logic clk, rst, psel, pen, pwr, run, stx, otx, serr;
logic [7:0] pa;
logic [3:0] spd;
logic [31:0] pwd, prd;
logic [31:0] tab [0:4];
wire [31:0] prdata;
wire pready, pslverr, p_exp, p_spd, coax_o, opt_o, rx_o, slave, wck;
wire [1:0] ref_sel;
wire [17:0] rate;
int failures, tests_run, n, cyc, lag;
audio_src_model src (.run_i(run), .exp_o(p_exp), .spdif_o(p_spd));
audio_sync_source_select #(.GATE_CYCLES(GATE)) dut (.CLK_I(clk), .RESET_I(rst), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .WCK_IN_I(1'b0), .OPT_IN_I(1'b0), .EXP_IN_I(p_exp), .SPDIF_OPT_I(spd[0]),
    .SPDIF_COAX_I(run ? p_spd : spd[1]), .SPDIF_INT_I(spd[2]), .SPDIF_AES_I(spd[3]), .SPDIF_TX_I(stx),
    .OPT_TX_I(otx), .SPDIF_COAX_O(coax_o), .OPT_OUT_O(opt_o), .SPDIF_RX_O(rx_o), .WCK_OUT_O(wck),
    .SLAVE_O(slave), .REF_SEL_O(ref_sel), .SAMPLE_RATE_O(rate));
task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
        $display("SIMULATION PASSED");
    else
        $display("SIMULATION FAILED");
    $finish;
endtask
task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
        failures++;
        $display("mismatch %s expected %h seen %h", nm, e, g);
    end
endtask
// measured rates may miss an edge at window borders
task near(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if ((g + 32'h0000_0002 >= e && g <= e + 32'h0000_0002) !== 1'b1) begin
        failures++;
        $display("mismatch %s expected %h seen %h", nm, e, g);
    end
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
        @(posedge clk);
        n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
        failures++;
        tally_and_finish;
    end
    prd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
endtask
task rd(input logic [7:0] a);
    repeat (3) @(posedge clk);
    apb(1'b0, a, 32'h0000_0000);
endtask
task hold(input logic v, input int lim);
    n = 0;
    while (slave !== v && n < lim) begin
        @(posedge clk);
        n++;
    end
    if (n >= lim) begin
        failures++;
        tally_and_finish;
    end
endtask
// waits for a word clock output level; n keeps counting cycles
task wait_lvl(input logic v);
    int m;
    m = 0;
    while (wck !== v && m < 6000) begin
        @(posedge clk);
        m++;
        n++;
    end
    if (m >= 6000) begin
        failures++;
        tally_and_finish;
    end
endtask
// skips a partial period, then leaves one rise-to-rise period in n
task wck_period;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    n = 0;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
endtask
initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
end
// cycles since reset release
always @(posedge clk)
    cyc <= rst ? 0 : cyc + 1;
initial begin
    {rst, psel, pen, pwr, run, stx, otx, pa, spd, pwd} = {5'h11, 2'h0, 8'h00, 4'h0, 32'h0000_0000};
    failures = 0;
    tests_run = 0;
    tab = '{32'h0001_7700, 32'h0001_7760, 32'h0001_76A0, 32'h0001_8600, 32'h0001_6800};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(`A_CTRL); chk("ctrl", 32'h0000_0000, prd);
    rd(`A_BASE); chk("base", 32'h0000_BB80, prd);
    rd(`A_PLAY); chk("play", 32'h0000_BB80, prd);
    apb(1'b0, 8'h24, 32'h0000_0000); chk("slverr", 32'h0000_0001, 32'(serr));
    apb(1'b1, `A_PLAY, 32'h0000_7530);
    apb(1'b1, `A_CTRL, 32'h0000_0089);
    // edges before the input select landed are lost from the first window
    lag = cyc + 1;
    rd(`A_SPDIF_RATE); chk("spdif_rate", 32'h0000_0000, prd);
    chk("ref_none", 32'h0000_0003, 32'(ref_sel));
    chk("master", 32'h0000_0000, 32'(slave));
    chk("rate", 32'h0000_7530, 32'(rate));
    $display("test idle done");
    hold(1'b1, 70000);
    repeat (2) @(posedge clk);
    chk("ref_sel", 32'h0000_0001, 32'(ref_sel));
    rd(`A_STATUS); chk("status", 32'h0000_0168, prd);
    rd(`A_REF_RATE); near("ref_rate", 32'h0000_7530 - 32'(lag / 2), prd);
    apb(1'b1, `A_SPDIF_RATE, 32'h0000_0000);
    rd(`A_SPDIF_RATE); near("spdif_rate", 32'h0000_7530 - 32'(lag / 2), prd);
    run <= 1'b0;
    apb(1'b1, `A_CTRL, 32'h0000_0000);
    hold(1'b0, 20);
    chk("ref_int", 32'h0000_0003, 32'(ref_sel));
    $display("test follow done");
    for (int k = 0; k < 4; k++) begin
        apb(1'b1, `A_CTRL, 32'(k) << 3);
        spd <= 4'h1 << k;
        repeat (5) @(posedge clk);
        chk("rx_hi", 32'h0000_0001, 32'(rx_o));
        spd <= ~(4'h1 << k);
        repeat (5) @(posedge clk);
        chk("rx_lo", 32'h0000_0000, 32'(rx_o));
    end
    spd <= 4'hF;
    repeat (6) @(posedge clk);
    apb(1'b1, `A_CTRL, 32'h0000_0020);
    stx <= 1'b1;
    repeat (2) @(posedge clk);
    chk("opt_out", 32'h0000_0001, 32'(opt_o));
    chk("coax_out", 32'h0000_0001, 32'(coax_o));
    apb(1'b1, `A_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk("opt_own", 32'h0000_0000, 32'(opt_o));
    $display("test routing done");
    apb(1'b1, `A_COARSE, 32'h0000_000A);
    apb(1'b1, `A_FINE, 32'h0000_FFFD);
    for (int p = 0; p < 5; p++) begin
        apb(1'b1, `A_CTRL, 32'h0000_4100 | (32'(p) << 11));
        rd(`A_INT_RATE); chk("preset", tab[p], prd);
    end
    apb(1'b1, `A_CTRL, 32'h0000_4100);
    wck_period;
    near("wck_full", 32'h0000_0516, 32'(n));
    apb(1'b1, `A_CTRL, 32'h0000_4140);
    wck_period;
    near("wck_base", 32'h0000_0A2C, 32'(n));
    apb(1'b1, `A_CTRL, 32'h0000_4700);
    rd(`A_INT_RATE); chk("faders", 32'h0001_7707, prd);
    apb(1'b1, `A_CTRL, 32'h0000_4600);
    rd(`A_INT_RATE); chk("synth_off", 32'h0000_7530, prd);
    $display("test synth done");
    tally_and_finish;
end
endmodule // tb_audio_sync_source_select
bind audio_sync_source_select audio_sync_checks #(.GATE_CYCLES(GATE_CYCLES)) chk_i (.CLK_I(CLK_I),
    .RESET_I(RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .PRDATA_O(PRDATA_O), .SPDIF_TX_I(SPDIF_TX_I), .OPT_TX_I(OPT_TX_I), .SPDIF_OPT_I(SPDIF_OPT_I),
    .SPDIF_COAX_I(SPDIF_COAX_I), .SPDIF_INT_I(SPDIF_INT_I), .SPDIF_AES_I(SPDIF_AES_I),
    .SPDIF_COAX_O(SPDIF_COAX_O), .OPT_OUT_O(OPT_OUT_O), .SPDIF_RX_O(SPDIF_RX_O), .SLAVE_O(SLAVE_O),
    .REF_SEL_O(REF_SEL_O));
`default_nettype wire
